//--- hw/load_cmd_pkg.sv
// Constants for the load state and system command unit.
// Assumes a decoded command stream from a text parser upstream.
`default_nettype none

package load_cmd_pkg;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [4:0] CMD_PRESET_SET  = 5'h01;
  localparam logic [4:0] CMD_PRESET_Q    = 5'h02;
  localparam logic [4:0] CMD_SENSE_SET   = 5'h03;
  localparam logic [4:0] CMD_SENSE_Q     = 5'h04;
  localparam logic [4:0] CMD_LEVEL_SET   = 5'h05;
  localparam logic [4:0] CMD_LEVEL_Q     = 5'h06;
  localparam logic [4:0] CMD_DYN_SET     = 5'h07;
  localparam logic [4:0] CMD_DYN_Q       = 5'h08;
  localparam logic [4:0] CMD_CLEAR       = 5'h09;
  localparam logic [4:0] CMD_ERROR_Q     = 5'h0a;
  localparam logic [4:0] CMD_NG_Q        = 5'h0b;
  localparam logic [4:0] CMD_PROTECTION_STATUS_Q      = 5'h0c;
  localparam logic [4:0] CMD_RANGE       = 5'h0d;
  localparam logic [4:0] CMD_POLARITY    = 5'h0e;
  localparam logic [4:0] CMD_START       = 5'h0f;
  localparam logic [4:0] CMD_STOP        = 5'h10;
  localparam logic [4:0] CMD_RECALL      = 5'h11;
  localparam logic [4:0] CMD_SAVE        = 5'h12;
  localparam logic [4:0] CMD_NAME_Q      = 5'h13;
  localparam logic [4:0] CMD_RESET       = 5'h14;
  localparam logic [4:0] CMD_REMOTE      = 5'h15;
  localparam logic [4:0] CMD_LOCAL       = 5'h16;
  localparam logic [4:0] CMD_SYNC_LOAD   = 5'h17;
  localparam logic [4:0] CMD_TEST_CONFIGURATION_SET = 5'h18;

  // ----------------------------------------------------------------
  // Argument encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] SENSE_OFF  = 2'h0;
  localparam logic [1:0] SENSE_ON   = 2'h1;
  localparam logic [1:0] SENSE_AUTO = 2'h2;
  localparam logic [2:0] TEST_NORMAL = 3'h0;
  localparam logic [2:0] TEST_OCP    = 3'h1;
  localparam logic [2:0] TEST_OVP    = 3'h2;
  localparam logic [2:0] TEST_OPP    = 3'h3;
  localparam logic [2:0] TEST_SHORT  = 3'h4;

  // ----------------------------------------------------------------
  // Field positions and sizes
  // ----------------------------------------------------------------
  localparam int ERR_CHAN_LO  = 0;
  localparam int ERR_OP_BIT   = 4;
  localparam int ERR_CMD_BIT  = 5;
  localparam int PROTECTION_STATUS_OPP_BIT = 0;
  localparam int PROTECTION_STATUS_OTP_BIT = 1;
  localparam int PROTECTION_STATUS_OVP_BIT = 2;
  localparam int PROTECTION_STATUS_OCP_BIT = 3;
  localparam int NUM_BANKS    = 15;
  localparam int NUM_STATES   = 10;
  localparam int NAME_CHARS   = 5;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [5:0] ERR_RESET   = 6'h00;
  localparam logic [3:0] PROTECTION_STATUS_RESET  = 4'h0;
  localparam logic [3:0] BANK_RESET  = 4'h1;
  localparam logic [2:0] TEST_RESET  = TEST_NORMAL;
  // Static operation after reset reads 1
  localparam logic       STATIC_RESET = 1'b1;

endpackage : load_cmd_pkg

`default_nettype wire

//--- hw/load_cmd_unit.sv
// Operation
// RQ1: Preset query answers 1 when preset on, 0 when off.
// RQ2: Sense accepts on, off, auto; query gives 1 only for on.
// RQ3: Level query gives 0 at low level, 1 at high level.
// RQ4: Dynamic query gives 0 in dynamic, 1 in static operation.
// RQ5: Clear command zeroes protection and error status registers.
// RQ6: Error bits: 0-3 channel, 4 operation, 5 command error.
// RQ7: Error query returns error register; bits stay until clear.
// RQ8: Protection bits: 0 power, 1 temperature, 2 voltage, 3 current.
// RQ9: Protection query returns register without changing it.
// RQ10: No-good query returns 1 while flag lit, else 0.
// RQ11: Range command selects auto range or forced second range.
// RQ12: Polarity command selects positive or negative voltage display.
// RQ13: Start begins the test chosen by the test configuration.
// RQ14: Stop ends a running test, else does nothing.
// RQ15: Setup memory is 15 banks of 10 states.
// RQ16: Recall takes state 1-10, optional bank 1-15, else current.
// RQ17: Save stores setup at state 1-10, optional bank, else current.
// RQ18: Name query returns fixed model string, number five characters.
// RQ19: Reset command returns load settings to defaults.
// RQ20: Enter-remote enables control over the host link.
// RQ21: Leave-remote ends remote status and closes the link.
// RQ22: Synchronous load on/off switches all channels together.
// RQ23: Test configuration picks normal, current, voltage, power, short.
// RQ24: Out-of-range index rejected, memory kept, operation error set.
//
// Command unit of an electronic load; one decoded command per strobe.
// Assumes the upstream parser flags syntax errors and event pulses
// come from logic on ref_clk.
`timescale 1ns/100ps
`default_nettype none

module load_cmd_unit
  import load_cmd_pkg::*;
#(
  parameter int        SETUP_W  = 16,
  parameter logic [39:0] MODEL_ID = 40'h4d4f44454c  // Arbitrary value
)(
  input  wire logic               ref_clk,
  input  wire logic               reset_n,
  input  wire logic               cmd_valid,
  input  wire logic [4:0]         cmd_code,
  input  wire logic [2:0]         cmd_arg,
  input  wire logic [3:0]         state_index,
  input  wire logic [3:0]         bank_index,
  input  wire logic               bank_given,
  input  wire logic               syntax_error,
  input  wire logic [3:0]         channel_error,
  input  wire logic               over_power_trip,
  input  wire logic               over_temp_trip,
  input  wire logic               over_voltage_trip,
  input  wire logic               over_current_trip,
  input  wire logic               no_good_flag,
  input  wire logic               level_high,
  input  wire logic               test_done,
  input  wire logic [SETUP_W-1:0] live_setup,
  output logic                    reply_valid,
  output logic [39:0]             reply_data,
  output logic [5:0]              error_status,
  output logic [3:0]              protection_status,
  output logic                    preset_on,
  output logic [1:0]              sense_mode,
  output logic                    static_operation,
  output logic                    current_range_select,
  output logic                    meter_polarity,
  output logic [2:0]              test_configuration,
  output logic                    test_running,
  output logic                    remote_enable,
  output logic                    sync_load_on,
  output logic                    recall_valid,
  output logic [SETUP_W-1:0]      recall_setup,
  output logic [3:0]              current_bank
);

  if (SETUP_W < 1 || SETUP_W > 256)
  begin : g_bad_setup_w
    $error("SETUP_W out of range");
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic [3:0] eff_bank;
  logic       index_ok;
  logic       mem_cmd;
  logic [7:0] slot;
  logic [SETUP_W-1:0] setup_mem [NUM_BANKS*NUM_STATES];

  assign eff_bank = bank_given ? bank_index : current_bank; // RQ16 RQ17
  assign index_ok = state_index >= 4'h1
                  && state_index <= 4'(NUM_STATES)
                  && eff_bank >= 4'h1
                  && eff_bank <= 4'(NUM_BANKS);                 // RQ24
  assign mem_cmd  = cmd_valid
                  && (cmd_code == CMD_RECALL || cmd_code == CMD_SAVE);
  assign slot     = 8'(eff_bank - 4'h1) * 8'(NUM_STATES)
                  + 8'(state_index - 4'h1);                     // RQ15

  // ----------------------------------------------------------------
  // Status registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      error_status <= ERR_RESET;
    else
    begin
      // Set wins over clear in the same cycle
      error_status <= ((cmd_valid && cmd_code == CMD_CLEAR)
                      ? ERR_RESET : error_status)                // RQ5 RQ7
                    | {syntax_error,
                       mem_cmd && !index_ok,                     // RQ24
                       channel_error};                           // RQ6
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      protection_status <= PROTECTION_STATUS_RESET;
    else
    begin
      protection_status <= ((cmd_valid && cmd_code == CMD_CLEAR)
                           ? PROTECTION_STATUS_RESET : protection_status)     // RQ5
                         | {over_current_trip, over_voltage_trip,
                            over_temp_trip, over_power_trip};    // RQ8
    end
  end

  // ----------------------------------------------------------------
  // Settings
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      preset_on            <= 1'b0;
      sense_mode           <= SENSE_OFF;
      static_operation     <= STATIC_RESET;
      current_range_select <= 1'b0;
      meter_polarity       <= 1'b0;
      test_configuration   <= TEST_RESET;
      sync_load_on         <= 1'b0;
      current_bank         <= BANK_RESET;
    end
    else if (cmd_valid)
    begin
      case (cmd_code)
        CMD_PRESET_SET: preset_on <= cmd_arg[0];                 // RQ1
        CMD_SENSE_SET:
          if (cmd_arg[1:0] != 2'h3)
            sense_mode <= cmd_arg[1:0];                          // RQ2
        CMD_DYN_SET:    static_operation <= !cmd_arg[0];         // RQ4
        CMD_RANGE:      current_range_select <= cmd_arg[0];      // RQ11
        CMD_POLARITY:   meter_polarity <= cmd_arg[0];            // RQ12
        CMD_TEST_CONFIGURATION_SET:
          if (cmd_arg <= TEST_SHORT)
            test_configuration <= cmd_arg;                       // RQ23
        CMD_SYNC_LOAD:  sync_load_on <= cmd_arg[0];              // RQ22
        CMD_RECALL, CMD_SAVE:
          if (bank_given && index_ok)
            current_bank <= bank_index;
        CMD_RESET:                                               // RQ19
        begin
          preset_on            <= 1'b0;
          sense_mode           <= SENSE_OFF;
          static_operation     <= STATIC_RESET;
          current_range_select <= 1'b0;
          meter_polarity       <= 1'b0;
          test_configuration   <= TEST_RESET;
          sync_load_on         <= 1'b0;
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Test control and remote state
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      test_running <= 1'b0;
    else if (cmd_valid && cmd_code == CMD_START)
      test_running <= 1'b1;                                      // RQ13
    else if ((cmd_valid && (cmd_code == CMD_STOP
              || cmd_code == CMD_RESET)) || test_done)
      test_running <= 1'b0;                                      // RQ14
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      remote_enable <= 1'b0;
    else if (cmd_valid && cmd_code == CMD_REMOTE)
      remote_enable <= 1'b1;                                     // RQ20
    else if (cmd_valid && cmd_code == CMD_LOCAL)
      remote_enable <= 1'b0;                                     // RQ21
  end

  // ----------------------------------------------------------------
  // Setup memory
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (cmd_valid && cmd_code == CMD_SAVE && index_ok)
      setup_mem[slot] <= live_setup;                             // RQ17
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      recall_valid <= 1'b0;
      recall_setup <= '0;
    end
    else
    begin
      recall_valid <= cmd_valid && cmd_code == CMD_RECALL && index_ok;
      if (cmd_valid && cmd_code == CMD_RECALL && index_ok)
        recall_setup <= setup_mem[slot];                         // RQ16
    end
  end

  // ----------------------------------------------------------------
  // Query replies
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      reply_valid <= 1'b0;
      reply_data  <= 40'h0;
    end
    else
    begin
      reply_valid <= 1'b0;
      if (cmd_valid)
      begin
        case (cmd_code)
          CMD_PRESET_Q:
          begin
            reply_valid <= 1'b1;
            reply_data  <= {39'h0, preset_on};                   // RQ1
          end
          CMD_SENSE_Q:
          begin
            reply_valid <= 1'b1;
            reply_data  <= {39'h0, sense_mode == SENSE_ON};      // RQ2
          end
          CMD_LEVEL_Q:
          begin
            reply_valid <= 1'b1;
            reply_data  <= {39'h0, level_high};                  // RQ3
          end
          CMD_DYN_Q:
          begin
            reply_valid <= 1'b1;
            reply_data  <= {39'h0, static_operation};            // RQ4
          end
          CMD_ERROR_Q:
          begin
            reply_valid <= 1'b1;
            reply_data  <= {34'h0, error_status};                // RQ7
          end
          CMD_NG_Q:
          begin
            reply_valid <= 1'b1;
            reply_data  <= {39'h0, no_good_flag};                // RQ10
          end
          CMD_PROTECTION_STATUS_Q:
          begin
            reply_valid <= 1'b1;
            reply_data  <= {36'h0, protection_status};           // RQ9
          end
          CMD_NAME_Q:
          begin
            reply_valid <= 1'b1;
            reply_data  <= MODEL_ID;                             // RQ18
          end
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_clear_zeroes: assert property ( // RQ5
    @(posedge ref_clk) disable iff (!reset_n)
    cmd_valid && cmd_code == CMD_CLEAR && !syntax_error
    && channel_error == 4'h0
    |=> error_status == ERR_RESET)
    else $error("error status not cleared");
  a_protection_status_clear: assert property ( // RQ5
    @(posedge ref_clk) disable iff (!reset_n)
    cmd_valid && cmd_code == CMD_CLEAR && !over_power_trip
    && !over_temp_trip && !over_voltage_trip && !over_current_trip
    |=> protection_status == PROTECTION_STATUS_RESET)
    else $error("protection status not cleared");
  a_protection_status_sticky: assert property ( // RQ9
    @(posedge ref_clk) disable iff (!reset_n)
    !(cmd_valid && cmd_code == CMD_CLEAR)
    |=> (protection_status & $past(protection_status))
        == $past(protection_status))
    else $error("protection bit lost");
  a_err_sticky: assert property ( // RQ7
    @(posedge ref_clk) disable iff (!reset_n)
    !(cmd_valid && cmd_code == CMD_CLEAR)
    |=> (error_status & $past(error_status)) == $past(error_status))
    else $error("error bit lost");
  a_trip_sets: assert property ( // RQ8
    @(posedge ref_clk) disable iff (!reset_n)
    over_voltage_trip |=> protection_status[PROTECTION_STATUS_OVP_BIT])
    else $error("voltage trip not held");
  a_bad_index: assert property ( // RQ24
    @(posedge ref_clk) disable iff (!reset_n)
    mem_cmd && !index_ok |=> error_status[ERR_OP_BIT] && !recall_valid)
    else $error("bad index not flagged");
  a_error_reply: assert property ( // RQ7
    @(posedge ref_clk) disable iff (!reset_n)
    cmd_valid && cmd_code == CMD_ERROR_Q
    |=> reply_valid && reply_data[5:0] == $past(error_status))
    else $error("error reply wrong");
  a_sense_reply: assert property ( // RQ2
    @(posedge ref_clk) disable iff (!reset_n)
    cmd_valid && cmd_code == CMD_SENSE_Q
    |=> reply_valid && reply_data[0] == ($past(sense_mode) == SENSE_ON))
    else $error("sense reply wrong");
  a_stop_ends: assert property ( // RQ14
    @(posedge ref_clk) disable iff (!reset_n)
    cmd_valid && cmd_code == CMD_STOP |=> !test_running)
    else $error("stop did not end test");
  a_start_runs: assert property ( // RQ13
    @(posedge ref_clk) disable iff (!reset_n)
    cmd_valid && cmd_code == CMD_START |=> test_running)
    else $error("start did not run test");
  a_remote_enter: assert property ( // RQ20
    @(posedge ref_clk) disable iff (!reset_n)
    cmd_valid && cmd_code == CMD_REMOTE |=> remote_enable)
    else $error("remote not entered");
  a_remote_link: assert property ( // RQ21
    @(posedge ref_clk) disable iff (!reset_n)
    cmd_valid && cmd_code == CMD_LOCAL |=> !remote_enable)
    else $error("local did not leave remote");

endmodule : load_cmd_unit

`default_nettype wire

//--- test/host_cmd_model.sv
// Host model: issues one decoded command per strobe.
// Assumes ref_clk from the bench; fields are scrambled between strobes.
`timescale 1ns/100ps
`default_nettype none

module host_cmd_model
  import load_cmd_pkg::*;
(
  input  wire logic       ref_clk,
  output logic            cmd_valid,
  output logic [4:0]      cmd_code,
  output logic [2:0]      cmd_arg,
  output logic [3:0]      state_index,
  output logic [3:0]      bank_index,
  output logic            bank_given
);
  // ----------------------------------------------------------------
  // Command strobe
  // ----------------------------------------------------------------
  initial
  begin
    {cmd_valid, cmd_code, cmd_arg} = '0;
    {state_index, bank_index, bank_given} = '0;
  end

  task automatic send(input logic [4:0] c, input logic [2:0] a,
                      input logic [3:0] s, input logic [3:0] b,
                      input logic g);
    @(posedge ref_clk);
    #1;
    {cmd_code, cmd_arg} = {c, a};
    {state_index, bank_index, bank_given} = {s, b, g};
    cmd_valid = 1'b1;
    @(posedge ref_clk);
    #1;
    cmd_valid = 1'b0;
    // Stale fields inverted
    {cmd_code, cmd_arg} = ~{c, a};
    {state_index, bank_index, bank_given} = ~{s, b, g};
  endtask : send
endmodule : host_cmd_model
`default_nettype wire

//--- test/load_state_system_command_unit_test.sv
// Bench for the load command unit with a score model of its state.
// Assumes load_cmd_pkg, load_cmd_unit and host_cmd_model compiled first.
`timescale 1ns/100ps
`default_nettype none

module load_state_system_command_unit_test
  import load_cmd_pkg::*;
;
  // Arbitrary value
  localparam logic [39:0] NAME_VAL = 40'h6c6f616431;
  logic        ref_clk, reset_n, cmd_valid, bank_given, syntax_error;
  logic        no_good_flag, level_high, test_end, reply_valid;
  logic        preset_on, static_operation, current_range_select;
  logic        meter_polarity, test_running, remote_enable;
  logic        sync_load_on, recall_valid;
  logic [4:0]  cmd_code;
  logic [2:0]  cmd_arg, test_configuration;
  logic [3:0]  state_index, bank_index, channel_error, trips;
  logic [3:0]  protection_status, current_bank, exp_protection_status;
  logic [15:0] live_setup, recall_setup;
  logic [15:0] mem [int];
  logic [39:0] reply_data;
  logic [5:0]  error_status, exp_err;
  logic [1:0]  sense_mode;
  int          error_cnt, checked, cycles, exp_bank;

  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  host_cmd_model host_u (.ref_clk, .cmd_valid, .cmd_code, .cmd_arg,
    .state_index, .bank_index, .bank_given);

  load_cmd_unit #(.SETUP_W(16), .MODEL_ID(NAME_VAL)) dut_u (.ref_clk,
    .reset_n, .cmd_valid, .cmd_code, .cmd_arg, .state_index, .bank_index,
    .bank_given, .syntax_error, .channel_error,
    .over_power_trip(trips[0]), .over_temp_trip(trips[1]),
    .over_voltage_trip(trips[2]), .over_current_trip(trips[3]),
    .no_good_flag, .level_high, .test_done(test_end), .live_setup,
    .reply_valid, .reply_data, .error_status, .protection_status,
    .preset_on, .sense_mode, .static_operation, .current_range_select,
    .meter_polarity, .test_configuration, .test_running, .remote_enable,
    .sync_load_on, .recall_valid, .recall_setup, .current_bank);

  // ----------------------------------------------------------------
  // Compare and stimulus tasks
  // ----------------------------------------------------------------
  task automatic chk_val(input logic [39:0] got, input logic [39:0] exp,
                         input string what);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %0t %s: got %h want %h", $time, what, got,
               exp);
    end
  endtask : chk_val

  task automatic chk_reply(input logic [39:0] exp);
    chk_val(40'(reply_valid), 40'h1, "reply strobe");
    chk_val(reply_data, exp, "reply data");
  endtask : chk_reply

  task automatic cmd(input logic [4:0] c, input logic [2:0] a);
    host_u.send(c, a, 4'h0, 4'h0, 1'b0);
  endtask : cmd

  task automatic q(input logic [4:0] c, input logic [39:0] exp);
    cmd(c, 3'h0);
    chk_reply(exp);
  endtask : q

  task automatic pulse(input logic [3:0] tr, input logic [3:0] ch,
                       input logic sy);
    @(posedge ref_clk);
    #1;
    {trips, channel_error, syntax_error} = {tr, ch, sy};
    @(posedge ref_clk);
    #1;
    {trips, channel_error, syntax_error} = '0;
    exp_protection_status |= tr;
    exp_err |= {sy, 1'b0, ch};
  endtask : pulse

  task automatic mem_op(input logic [4:0] c, input int s, input int b,
                        input logic g);
    int bk;
    bk = g ? b : exp_bank;
    live_setup = 16'($urandom);
    host_u.send(c, 3'h0, 4'(s), 4'(b), g);
    if (s < 1 || s > NUM_STATES || bk < 1 || bk > NUM_BANKS)
    begin
      exp_err[ERR_OP_BIT] = 1'b1;
      chk_val(40'(recall_valid), 40'h0, "refused recall");
    end
    else if (c == CMD_SAVE)
    begin
      exp_bank = bk;
      mem[bk * 16 + s] = live_setup;
    end
    else
    begin
      exp_bank = bk;
      chk_val(40'(recall_valid), 40'h1, "recall strobe");
      chk_val(40'(recall_setup), 40'(mem[bk * 16 + s]), "recall");
    end
    chk_val(40'(current_bank), 40'(exp_bank), "bank");
    chk_val(40'(error_status), 40'(exp_err), "error reg");
  endtask : mem_op

  task automatic test_done();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      error_cnt++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(32'hb73f51bf));
    reset_n = 1'b0;
    {syntax_error, channel_error, trips, no_good_flag} = '0;
    {level_high, test_end, live_setup} = '0;
    {exp_err, exp_protection_status} = '0;
    exp_bank = 1;
    repeat (3) @(posedge ref_clk);
    #1;
    reset_n = 1'b1;
    chk_val(40'({static_operation, current_bank}), 40'h11, "reset");
    chk_val(40'({error_status, protection_status}), 40'h0, "reset st");
    for (int i = 0; i < 3; i++)
    begin
      cmd(CMD_PRESET_SET, 3'(i & 1));
      q(CMD_PRESET_Q, 40'(i & 1));
      cmd(CMD_SENSE_SET, 3'(i));
      q(CMD_SENSE_Q, 40'(i == 1));
      cmd(CMD_DYN_SET, 3'(i & 1));
      q(CMD_DYN_Q, 40'(~i & 1));
      level_high = 1'($urandom);
      q(CMD_LEVEL_Q, 40'(level_high));
      no_good_flag = 1'(i & 1);
      q(CMD_NG_Q, 40'(i & 1));
      cmd(CMD_RANGE, 3'(i & 1));
      cmd(CMD_POLARITY, 3'(~i & 1));
      chk_val(40'({current_range_select, meter_polarity}),
              40'((i & 1) + 1), "range pol");
    end
    pulse(4'h0, 4'(($urandom % 15) + 1), 1'b1);
    for (int b = 0; b < 4; b++)
    begin
      pulse(4'(1 << b), 4'h0, 1'b0);
      q(CMD_PROTECTION_STATUS_Q, 40'(exp_protection_status));
    end
    q(CMD_PROTECTION_STATUS_Q, 40'(exp_protection_status));
    q(CMD_ERROR_Q, 40'(exp_err));
    cmd(CMD_CLEAR, 3'h0);
    {exp_err, exp_protection_status} = '0;
    q(CMD_ERROR_Q, 40'h0);
    chk_val(40'(protection_status), 40'h0, "protection_status clear");
    for (int t = 0; t < 5; t++)
    begin
      cmd(CMD_TEST_CONFIGURATION_SET, 3'(t));
      cmd(CMD_START, 3'h0);
      chk_val(40'({test_running, test_configuration}), 40'(8 + t),
              "start");
      cmd(CMD_STOP, 3'h0);
      cmd(CMD_STOP, 3'h0);
      chk_val(40'({test_running, test_configuration}), 40'(t),
              "stop");
    end
    cmd(CMD_START, 3'h0);
    @(posedge ref_clk);
    #1;
    test_end = 1'b1;
    @(posedge ref_clk);
    #1;
    test_end = 1'b0;
    chk_val(40'(test_running), 40'h0, "test end");
    cmd(CMD_PRESET_SET, 3'h1);
    cmd(CMD_SENSE_SET, 3'(SENSE_ON));
    cmd(CMD_DYN_SET, 3'h1);
    cmd(CMD_START, 3'h0);
    cmd(CMD_RESET, 3'h0);
    chk_val(40'({current_range_select, meter_polarity, preset_on,
            sense_mode, static_operation, test_running,
            test_configuration}), 40'h10, "defaults");
    cmd(CMD_REMOTE, 3'h0);
    cmd(CMD_SYNC_LOAD, 3'h1);
    chk_val(40'({remote_enable, sync_load_on}), 40'h3, "on");
    cmd(CMD_LOCAL, 3'h0);
    cmd(CMD_SYNC_LOAD, 3'h0);
    chk_val(40'({remote_enable, sync_load_on}), 40'h0, "off");
    q(CMD_NAME_Q, NAME_VAL);
    mem_op(CMD_SAVE, 1, 1, 1'b1);
    mem_op(CMD_SAVE, 10, 15, 1'b1);
    mem_op(CMD_SAVE, 3, 0, 1'b0);
    mem_op(CMD_SAVE, 11, 15, 1'b1);
    mem_op(CMD_SAVE, 1, 0, 1'b1);
    mem_op(CMD_RECALL, 0, 2, 1'b1);
    mem_op(CMD_RECALL, 10, 15, 1'b1);
    mem_op(CMD_RECALL, 3, 0, 1'b0);
    mem_op(CMD_RECALL, 1, 1, 1'b1);
    reset_n = 1'b0;
    @(posedge ref_clk);
    #1;
    reset_n = 1'b1;
    {exp_err, exp_protection_status} = '0;
    chk_val(40'({static_operation, error_status, current_bank}), 40'h401,
            "second reset");
    test_done();
  end
endmodule : load_state_system_command_unit_test
`default_nettype wire
